// *** common/adc_hs_pkg.sv ***
`default_nettype none
package adc_hs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RES_W = 12;
  localparam int unsigned FIFO_DEPTH = 4;
  // Conversion time, longest printed figure
  localparam int unsigned T_CONV_NS = 283;
  localparam int unsigned CONV_CYC = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Busy must fall within 20 ns of the start edge; longest time rounds down, floor of one
  localparam int unsigned T_BUSY_NS = 20;
  localparam int unsigned BUSY_CYC_RAW = T_BUSY_NS / CLK_PERIOD_NS;
  localparam int unsigned BUSY_CYC = (BUSY_CYC_RAW < 1) ? 1 : BUSY_CYC_RAW;
  // Data access after select falls
  localparam int unsigned T_ACCESS_NS = 45;
  localparam int unsigned ACCESS_CYC_RAW = T_ACCESS_NS / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC = (ACCESS_CYC_RAW < 1) ? 1 : ACCESS_CYC_RAW;
  localparam logic [3:0] CONV_CNT_MAX = 4'(CONV_CYC - 1);
  localparam logic [11:0] RESULT_RST = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic [RES_W-1:0] code;
  } result_s;
endpackage : adc_hs_pkg
`default_nettype wire

// *** hdl/sample_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo
`default_nettype wire

// *** hdl/sar_adc_conversion_handshake.sv ***
// Notes on behaviour
// - A high-to-low transition on conv_start_n starts a new conversion.
// - Start edges count only while select_n is low; the host asserts select first.
// - busy_n is low while a conversion runs and returns high when it ends.
// - busy_n falls no later than 20 ns after the start edge; here it falls on the fifth clock edge after the pin edge.
// - The result is valid on the bus at the busy_n rising edge, within 25 ns.
// - Valid data appears on result_bus within 45 ns of select_n falling; here the enables turn on at the fifth clock edge after it.
// - All twelve result_bus outputs are released whenever select_n is high.
// - Each result is a 12-bit parallel word, bit 11 the most significant.
// - Results are two's complement, bipolar zero toggling between all zeros and all ones; here bits 3 to 0 stay zero, so the negative side reads 0xFF0.
// - A running conversion ignores further start requests and cannot be restarted.
// - At the end of conversion the SAR word loads the output latch; only bits 11 to 4 get a trial, bits 3 to 0 stay zero.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_handshake
  import adc_hs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Host control pins
  input wire logic select_n,
  input wire logic conv_start_n,
  // Converter core: comparator decision per bit trial, and sampled analog hold
  input wire logic comp_above,
  output logic sample_hold_ff,
  // Status and data pins
  output logic busy_n_ff,
  output logic [RES_W-1:0] result_bus_ff,
  output logic [RES_W-1:0] result_bus_oe_ff,
  // Completed words stream, drained by the surrounding system
  output logic word_valid_ff,
  input wire logic word_ready,
  output logic [RES_W-1:0] word_data_ff
);
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  logic [2:0] sel_sync_ff;
  logic [2:0] cst_sync_ff;
  logic sel_n_ff;
  logic cst_n_ff;
  logic cst_n_prev_ff;

  wire sel_agree = (sel_sync_ff[1] == sel_sync_ff[2]);
  wire cst_agree = (cst_sync_ff[1] == cst_sync_ff[2]);
  wire nxt_sel_n = sel_agree ? sel_sync_ff[2] : sel_n_ff;
  wire nxt_cst_n = cst_agree ? cst_sync_ff[2] : cst_n_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_sync_ff <= 3'h7;
      cst_sync_ff <= 3'h7;
      sel_n_ff <= 1'b1;
      cst_n_ff <= 1'b1;
      cst_n_prev_ff <= 1'b1;
    end else begin
      sel_sync_ff <= {sel_sync_ff[1:0], select_n};
      cst_sync_ff <= {cst_sync_ff[1:0], conv_start_n};
      sel_n_ff <= nxt_sel_n;
      cst_n_ff <= nxt_cst_n;
      cst_n_prev_ff <= cst_n_ff;
    end
  end

  // Start edge detection, gated by select
  wire start_edge = cst_n_prev_ff && !cst_n_ff;
  wire start_ok = start_edge && !sel_n_ff;

  // Conversion sequencer
  conv_state_e state_ff;
  conv_state_e nxt_state;
  logic [3:0] conv_cnt_ff;
  logic [RES_W-1:0] sar_ff;
  logic [RES_W-1:0] trial_ff;
  logic [RES_W-1:0] latch_ff;

  wire in_idle = (state_ff == ST_IDLE);
  wire in_conv = (state_ff == ST_CONV);
  wire conv_done = in_conv && (conv_cnt_ff == CONV_CNT_MAX);
  wire bit_step = in_conv && (trial_ff != '0);
  // Trial bit kept if comparator says input lies above the DAC level; MSB trial is sign
  wire [RES_W-1:0] sar_keep = comp_above ? sar_ff : (sar_ff & ~trial_ff);
  wire [RES_W-1:0] sar_next_trial = sar_keep | (trial_ff >> 1);
  // Offset-binary SAR word to two's complement by inverting the MSB
  wire [RES_W-1:0] sar_final = bit_step ? sar_keep : sar_ff;
  wire [RES_W-1:0] twos_word = {~sar_final[RES_W-1], sar_final[RES_W-2:0]};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_ok) nxt_state = ST_CONV;
      end
      ST_CONV: begin
        if (conv_done) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      conv_cnt_ff <= 4'h0;
      sar_ff <= 12'h000;
      trial_ff <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      if (in_idle && start_ok) begin
        conv_cnt_ff <= 4'h0;
        sar_ff <= 12'h800;
        trial_ff <= 12'h800;
      end else if (in_conv) begin
        conv_cnt_ff <= conv_cnt_ff + 4'h1;
        if (bit_step) begin
          sar_ff <= sar_next_trial;
          trial_ff <= trial_ff >> 1;
        end
      end
    end
  end

  // Output latch and status
  wire load_latch = conv_done;
  wire [RES_W-1:0] nxt_latch = load_latch ? twos_word : latch_ff;

  // Stream of completed words into the FIFO; a full FIFO drops nothing from the pins
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [RES_W-1:0] fifo_out_data;
  wire drain = word_valid_ff && word_ready;
  wire fill_out = fifo_out_valid && (!word_valid_ff || drain);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_ff <= RESULT_RST;
      busy_n_ff <= 1'b1;
      sample_hold_ff <= 1'b0;
      result_bus_ff <= RESULT_RST;
      result_bus_oe_ff <= 12'h000;
      word_valid_ff <= 1'b0;
      word_data_ff <= RESULT_RST;
    end else begin
      latch_ff <= nxt_latch;
      busy_n_ff <= !(nxt_state == ST_CONV);
      sample_hold_ff <= (nxt_state == ST_CONV);
      result_bus_ff <= nxt_latch;
      result_bus_oe_ff <= {RES_W{!sel_n_ff}};
      if (fill_out) begin
        word_valid_ff <= 1'b1;
        word_data_ff <= fifo_out_data;
      end else if (drain) begin
        word_valid_ff <= 1'b0;
      end
    end
  end

  sample_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) sample_fifo_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(load_latch),
    .in_ready(fifo_in_ready),
    .in_data(twos_word),
    .out_valid(fifo_out_valid),
    .out_ready(!word_valid_ff || drain),
    .out_data(fifo_out_data)
  );

  // Stream overflow: a word finished while the FIFO is full is lost to the stream only
  logic overflow_ff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_ff <= 1'b0;
    end else if (load_latch && !fifo_in_ready) begin
      overflow_ff <= 1'b1;
    end
  end
  wire unused_ok = overflow_ff;
endmodule : sar_adc_conversion_handshake
`default_nettype wire

// *** testbench/adc_hs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_hs_chk
  import adc_hs_pkg::*;
(
  // Watched pins
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic select_n,
  input wire logic busy_n_ff,
  input wire logic sample_hold_ff,
  input wire logic [RES_W-1:0] result_bus_ff,
  input wire logic [RES_W-1:0] result_bus_oe_ff,
  input wire logic word_valid_ff,
  input wire logic word_ready,
  input wire logic [RES_W-1:0] word_data_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_BUSY_LEN: assert property ($fell(busy_n_ff) |-> (!busy_n_ff)[*7] ##[1:2] busy_n_ff)
    else $error("busy low length wrong");
  AST_RES_AT_BUSY: assert property (!$stable(result_bus_ff) |-> $rose(busy_n_ff))
    else $error("result moved away from busy rise");
  AST_OE_WHOLE: assert property (result_bus_oe_ff == '0 || result_bus_oe_ff == '1)
    else $error("bus enables split");
  AST_OE_OFF: assert property (select_n[*8] |-> result_bus_oe_ff == '0)
    else $error("bus driven while unselected");
  AST_OE_ON: assert property ((!select_n)[*8] |-> result_bus_oe_ff == '1)
    else $error("bus not driven while selected");
  AST_SEL_GATE: assert property (select_n[*8] |=> !$fell(busy_n_ff))
    else $error("conversion started while unselected");
  AST_HOLD: assert property ($fell(busy_n_ff) |-> sample_hold_ff)
    else $error("hold not set at conversion start");
  AST_WORD_STAND: assert property (word_valid_ff && !word_ready |=> word_valid_ff && $stable(word_data_ff))
    else $error("stream word dropped before taken");
  AST_WORD_AFTER: assert property ($rose(busy_n_ff) |-> ##[1:3] word_valid_ff)
    else $error("no stream word after conversion");
  COV_CONV: cover property ($fell(busy_n_ff));
  COV_TAKE: cover property (word_valid_ff && word_ready);
  COV_OE: cover property ($rose(result_bus_oe_ff[0]));
endmodule : adc_hs_chk
bind sar_adc_conversion_handshake adc_hs_chk adc_hs_chk_inst (.core_clk(core_clk),
  .sys_rst(sys_rst), .select_n(select_n), .busy_n_ff(busy_n_ff), .sample_hold_ff(sample_hold_ff),
  .result_bus_ff(result_bus_ff), .result_bus_oe_ff(result_bus_oe_ff),
  .word_valid_ff(word_valid_ff), .word_ready(word_ready), .word_data_ff(word_data_ff));
`default_nettype wire

// *** testbench/comp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module comp_model (
  // Clock, hold phase and chosen input level
  input wire logic core_clk,
  input wire logic sample_hold_ff,
  input wire logic level_hi,
  // Decision to the converter
  output logic comp_above
);
  logic wobble_ff = 1'b0;
  // Outside the hold phase the decision means nothing, so it wanders
  always @(posedge core_clk) wobble_ff <= !wobble_ff;
  assign comp_above = sample_hold_ff ? level_hi : wobble_ff;
endmodule : comp_model
`default_nettype wire

// *** testbench/sar_adc_conversion_handshake_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: value mismatch", $time); end end
module sar_adc_conversion_handshake_tb import adc_hs_pkg::*;;
  logic core_clk = 1'b0, sys_rst = 1'b1, select_n = 1'b1, conv_start_n = 1'b1;
  logic level_hi = 1'b1, word_ready = 1'b0, comp_above, sample_hold_ff, busy_n_ff, word_valid_ff;
  logic [RES_W-1:0] result_bus_ff, result_bus_oe_ff, word_data_ff;
  int errors = 0, checks = 0, n;
  always #20 core_clk = !core_clk;
  sar_adc_conversion_handshake sar_adc_conversion_handshake_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .select_n(select_n), .conv_start_n(conv_start_n), .comp_above(comp_above),
    .sample_hold_ff(sample_hold_ff), .busy_n_ff(busy_n_ff), .result_bus_ff(result_bus_ff),
    .result_bus_oe_ff(result_bus_oe_ff), .word_valid_ff(word_valid_ff),
    .word_ready(word_ready), .word_data_ff(word_data_ff));
  comp_model comp_model_inst (.core_clk(core_clk), .sample_hold_ff(sample_hold_ff),
    .level_hi(level_hi), .comp_above(comp_above));
  task give_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task step(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask : step
  task start_pulse;
    conv_start_n = 1'b0;
    step(3);
    conv_start_n = 1'b1;
    step(3);
  endtask : start_pulse
  task wait_busy(input logic lvl);
    n = 0;
    while (busy_n_ff !== lvl && n < 20) begin
      step(1);
      n++;
    end
    if (busy_n_ff !== lvl) begin
      errors++;
      give_verdict;
    end
  endtask : wait_busy
  task sc_convert(input logic lvl, input logic [7:0] top);
    level_hi = lvl;
    select_n = 1'b0;
    step(6);
    start_pulse;
    wait_busy(1'b0);
    `CHK(sample_hold_ff, 1'b1)
    wait_busy(1'b1);
    `CHK(result_bus_ff[11:4], top)
    `CHK(result_bus_oe_ff, 12'hfff)
    step(3);
  endtask : sc_convert
  task sc_unselected;
    select_n = 1'b1;
    step(8);
    `CHK(result_bus_oe_ff, 12'h000)
    start_pulse;
    `CHK(busy_n_ff, 1'b1)
    step(10);
    `CHK(busy_n_ff, 1'b1)
  endtask : sc_unselected
  task sc_restart;
    select_n = 1'b0;
    step(6);
    start_pulse;
    `CHK(busy_n_ff, 1'b0)
    start_pulse;
    step(4);
    `CHK(busy_n_ff, 1'b1)
  endtask : sc_restart
  task sc_fifo;
    word_ready = 1'b1;
    step(8);
    word_ready = 1'b0;
    repeat (6) sc_convert(1'b1, 8'h7f);
    word_ready = 1'b1;
    n = 0;
    repeat (10) begin
      if (word_valid_ff === 1'b1) begin
        `CHK(word_data_ff, 12'h7f0)
        n++;
      end
      step(1);
    end
    `CHK(n, FIFO_DEPTH + 1)
  endtask : sc_fifo
  initial begin
    step(12);
    sys_rst = 1'b0;
    `CHK(busy_n_ff, 1'b1)
    `CHK(result_bus_oe_ff, 12'h000)
    sc_convert(1'b1, 8'h7f);
    sc_convert(1'b0, 8'h80);
    sc_unselected;
    sc_restart;
    sc_fifo;
    give_verdict;
  end
endmodule : sar_adc_conversion_handshake_tb
`default_nettype wire
